/* File: src/mrsre_consts.vh */
// Constants for the move, rotate, subtract and return execution block.
`ifndef MRSRE_CONSTS_VH
`define MRSRE_CONSTS_VH
// Instruction codes written to the op field of the command register.
`define MRSRE_OP_NOP    4'h0
`define MRSRE_OP_LDLIT  4'h1
`define MRSRE_OP_STACC  4'h2
`define MRSRE_OP_RET    4'h3
`define MRSRE_OP_RETI   4'h4
`define MRSRE_OP_ROTL   4'h5
`define MRSRE_OP_ROTR   4'h6
`define MRSRE_OP_SUB    4'h7
// Register offsets on the Avalon-MM slave (byte addresses).
`define MRSRE_ADDR_CMD    4'h0
`define MRSRE_ADDR_ACC    4'h4
`define MRSRE_ADDR_STATUS 4'h8
`define MRSRE_ADDR_PC     4'hC
// Command register fields.
`define MRSRE_CMD_OP_LSB  0
`define MRSRE_CMD_DEST    4
`define MRSRE_CMD_FA_LSB  8
`define MRSRE_CMD_LIT_LSB 16
// Status register fields.
`define MRSRE_ST_C    0
`define MRSRE_ST_DIGIT 1
`define MRSRE_ST_Z    2
`define MRSRE_ST_IE   3
`define MRSRE_ST_BUSY 4
// Reset values.
`define MRSRE_RST_ACC 8'h00
`define MRSRE_RST_PC  13'h0000
// Instruction cycles taken by a subroutine or interrupt return.
`define MRSRE_RET_CYCLES 2'h2
`endif

/* File: src/mrsre_exec.v */
// Execution unit for literal load, store, no-op, returns, rotates, subtract.
`timescale 1ns/1ps
`include "mrsre_consts.vh"

module mrsre_exec (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [6:0]  file_addr,
  input  wire [7:0]  file_rdata,
  output reg  [7:0]  file_wdata,
  output reg         file_we,
  output reg         stack_pop,
  input  wire [12:0] stack_top_entry,
  output reg  [12:0] pc
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_RET2 = 2'h2;
  localparam ST_DONE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // State, datapath registers and their next values.
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [3:0]  op;
  reg         dest;
  reg  [7:0]  literal;
  reg  [7:0]  acc;
  reg  [7:0]  next_acc;
  reg         carry_flag;
  reg         next_carry_flag;
  reg         digit_carry_flag;
  reg         next_digit_carry_flag;
  reg         zero_flag;
  reg         next_zero_flag;
  reg         global_interrupt_enable;
  reg         next_global_interrupt_enable;
  reg  [12:0] next_pc;
  reg  [7:0]  next_file_wdata;
  reg         next_file_we;
  reg         next_stack_pop;

  wire        busy;
  wire        cmd_hit;
  wire        acc_hit;
  wire        status_hit;
  wire        op_is_left;
  wire [8:0]  rot_full;
  wire [8:0]  sub_full;
  wire [8:0]  sub_low;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when the bus address selects the given register offset.
  function reg_sel;
    input [3:0] addr;
    input [3:0] offset;
    begin
      reg_sel = (addr == offset);
    end
  endfunction

  // Minuend plus inverted subtrahend plus one; bit 8 is set when no borrow
  // leaves bit 7.
  function [8:0] sub_nb;
    input [7:0] minuend;
    input [7:0] subtrahend;
    begin
      sub_nb = {1'h0, minuend} + {1'h0, ~subtrahend} + 9'h001;
    end
  endfunction

  // Rotate through carry by one place; bit 8 holds the bit that leaves.
  function [8:0] rotc;
    input [7:0] value;
    input       carry_in;
    input       to_left;
    begin
      if (to_left) begin
        rotc = {value[7], value[6:0], carry_in};
      end else begin
        rotc = {value[0], carry_in, value[7:1]};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Datapath. The low nibbles are moved to the top of a byte so that the
  // carry out of the same subtractor gives the borrow from bit 3.
  assign op_is_left = (op == `MRSRE_OP_ROTL);
  assign rot_full   = rotc(file_rdata, carry_flag, op_is_left);
  assign sub_full   = sub_nb(file_rdata, acc);
  assign sub_low    = sub_nb({file_rdata[3:0], 4'h0}, {acc[3:0], 4'h0});

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave. Only a command write is ever held off, and only while a
  // command runs; register writes that arrive while busy are dropped.
  assign busy            = (state != ST_IDLE);
  assign cmd_hit         = avs_write && reg_sel(avs_address, `MRSRE_ADDR_CMD);
  assign acc_hit         = avs_write && avs_byteenable[0] &&
                           reg_sel(avs_address, `MRSRE_ADDR_ACC);
  assign status_hit      = avs_write && avs_byteenable[0] &&
                           reg_sel(avs_address, `MRSRE_ADDR_STATUS);
  assign avs_waitrequest = cmd_hit && busy;

  always @* begin
    if (reg_sel(avs_address, `MRSRE_ADDR_ACC)) begin
      avs_readdata = {24'h000000, acc};
    end else if (reg_sel(avs_address, `MRSRE_ADDR_STATUS)) begin
      avs_readdata = {27'h0000000, busy, global_interrupt_enable, zero_flag,
                      digit_carry_flag, carry_flag};
    end else if (reg_sel(avs_address, `MRSRE_ADDR_PC)) begin
      avs_readdata = {19'h00000, pc};
    end else begin
      avs_readdata = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command latch: the fields are taken only when a command is accepted, so
  // a command written while busy never disturbs the one that runs.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op        <= `MRSRE_OP_NOP;
      dest      <= 1'h0;
      file_addr <= 7'h00;
      literal   <= 8'h00;
    end else if (cmd_hit && !busy) begin
      op        <= avs_writedata[`MRSRE_CMD_OP_LSB+3:`MRSRE_CMD_OP_LSB];
      dest      <= avs_writedata[`MRSRE_CMD_DEST];
      file_addr <= avs_writedata[`MRSRE_CMD_FA_LSB+6:`MRSRE_CMD_FA_LSB];
      literal   <= avs_writedata[`MRSRE_CMD_LIT_LSB+7:`MRSRE_CMD_LIT_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values. Every result is written at the end of the execute cycle;
  // a return spends one more cycle while the program counter is redirected.
  always @* begin
    next_state                   = state;
    next_acc                     = acc;
    next_carry_flag              = carry_flag;
    next_digit_carry_flag        = digit_carry_flag;
    next_zero_flag               = zero_flag;
    next_global_interrupt_enable = global_interrupt_enable;
    next_pc                      = pc;
    next_file_wdata              = file_wdata;
    next_file_we                 = 1'h0;
    next_stack_pop               = 1'h0;
    case (state)
      ST_IDLE: begin
        if (cmd_hit) begin
          next_state = ST_EXEC;
        end else if (acc_hit) begin
          next_acc = avs_writedata[7:0];
        end else if (status_hit) begin
          next_carry_flag              = avs_writedata[`MRSRE_ST_C];
          next_digit_carry_flag        = avs_writedata[`MRSRE_ST_DIGIT];
          next_zero_flag               = avs_writedata[`MRSRE_ST_Z];
          next_global_interrupt_enable = avs_writedata[`MRSRE_ST_IE];
        end
      end
      ST_EXEC: begin
        next_state = ST_DONE;
        next_pc    = pc + 13'h0001;
        case (op)
          `MRSRE_OP_LDLIT: begin
            next_acc = literal;
          end
          `MRSRE_OP_STACC: begin
            next_file_wdata = acc;
            next_file_we    = 1'h1;
          end
          `MRSRE_OP_RET: begin
            next_pc        = stack_top_entry;
            next_stack_pop = 1'h1;
            next_state     = ST_RET2;
          end
          `MRSRE_OP_RETI: begin
            next_pc                      = stack_top_entry;
            next_stack_pop               = 1'h1;
            next_state                   = ST_RET2;
            next_global_interrupt_enable = 1'h1;
          end
          `MRSRE_OP_ROTL, `MRSRE_OP_ROTR: begin
            next_carry_flag = rot_full[8];
            if (dest) begin
              next_file_wdata = rot_full[7:0];
              next_file_we    = 1'h1;
            end else begin
              next_acc = rot_full[7:0];
            end
          end
          `MRSRE_OP_SUB: begin
            next_carry_flag       = sub_full[8];
            next_digit_carry_flag = sub_low[8];
            next_zero_flag        = (sub_full[7:0] == 8'h00);
            if (dest) begin
              next_file_wdata = sub_full[7:0];
              next_file_we    = 1'h1;
            end else begin
              next_acc = sub_full[7:0];
            end
          end
          default: begin
            next_file_we = 1'h0;
          end
        endcase
      end
      ST_RET2: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state. A command is busy from the cycle after acceptance
  // through its done state, which software sees in the status word.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= `MRSRE_RST_ACC;
    end else begin
      acc <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and the interrupt enable. They are cleared by reset and
  // otherwise change only through the instruction that owns them or a status write while idle.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_flag              <= 1'h0;
      digit_carry_flag        <= 1'h0;
      zero_flag               <= 1'h0;
      global_interrupt_enable <= 1'h0;
    end else begin
      carry_flag              <= next_carry_flag;
      digit_carry_flag        <= next_digit_carry_flag;
      zero_flag               <= next_zero_flag;
      global_interrupt_enable <= next_global_interrupt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter. It steps by one per instruction; a return loads the
  // popped stack top instead.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= `MRSRE_RST_PC;
    end else begin
      pc <= next_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write port. The strobe lasts one cycle and the data holds
  // until the next write, so a slow file can sample it late.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      file_wdata <= 8'h00;
      file_we    <= 1'h0;
    end else begin
      file_wdata <= next_file_wdata;
      file_we    <= next_file_we;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pop strobe, one cycle for each return.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_pop <= 1'h0;
    end else begin
      stack_pop <= next_stack_pop;
    end
  end

endmodule

/* File: tb/mrsre_exec_asserts.sv */
// Port checker for the execution block.
`timescale 1ns/1ps
module mrsre_chk (
  input wire        core_clk,
  input wire        arst_n,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [6:0]  file_addr,
  input wire        file_we,
  input wire        stack_pop,
  input wire [12:0] pc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_we_spaced: assert property (file_we |=> !file_we [*2])
    else $error("file write pulses too close");
  chk_pop_spaced: assert property (stack_pop |=> !stack_pop [*2])
    else $error("stack pops too close");
  chk_pop_no_we: assert property (stack_pop |-> !file_we)
    else $error("file written by a return");
  chk_wait_cmd: assert property (avs_waitrequest
    |-> avs_write && avs_address == 4'h0)
    else $error("wait outside a command write");
  chk_wait_bound: assert property (avs_waitrequest
    |-> ##[1:5] !avs_waitrequest)
    else $error("command wait too long");
  chk_rd_nowait: assert property (avs_read |-> !avs_waitrequest)
    else $error("read was held");
  chk_we_addr: assert property (file_we |-> $stable(file_addr))
    else $error("file address moved at write");
  chk_pc_step: assert property ($changed(pc) && !stack_pop
    && !$past(stack_pop) |-> pc == $past(pc) + 13'h1)
    else $error("program counter jumped");
endmodule
bind mrsre_exec mrsre_chk u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .file_addr(file_addr),
  .file_we(file_we), .stack_pop(stack_pop), .pc(pc));

/* File: tb/tb.sv */
// Self-checking bench for the execution block.
`timescale 1ns/1ps
`include "mrsre_consts.vh"
module tb;
  reg         core_clk = 1'b0;
  reg         arst_n = 1'b0;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [6:0]  file_addr;
  wire [7:0]  file_wdata;
  wire        file_we;
  wire        stack_pop;
  reg  [12:0] stack_top_entry = 13'h0;
  wire [12:0] pc;
  reg  [7:0]  fmem [0:127];
  reg  [31:0] rd;
  integer     err_total = 0;
  integer     n_compared = 0;
  integer     npop = 0;
  integer     i;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (file_we) fmem[file_addr] <= file_wdata;
    if (stack_pop) npop <= npop + 1;
  end
  mrsre_exec u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .file_addr(file_addr), .file_rdata(fmem[file_addr]),
    .file_wdata(file_wdata), .file_we(file_we), .stack_pop(stack_pop),
    .stack_top_entry(stack_top_entry), .pc(pc));
  task stop_test;
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  // Issues one command and polls status until idle; rd ends as status.
  task run(input [3:0] op, input d, input [6:0] fa, input [7:0] k);
    bus(1'h1, 4'h0, {8'h00, k, 1'h0, fa, 3'h0, d, op});
    i = 0;
    do begin
      bus(1'h0, 4'h8, 32'h0);
      i = i + 1;
    end while (rd[4] !== 1'b0 && i < 20);
  endtask
  initial begin
    #50000;
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    for (i = 0; i < 128; i = i + 1) fmem[i] = 8'h00;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'h1;
    bus(1'h0, `MRSRE_ADDR_PC, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 4'h1, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 4'h8, 32'h7);
    run(`MRSRE_OP_LDLIT, 1'h0, 7'h00, 8'hFF);
    chk(rd, 32'h7);
    bus(1'h0, 4'h4, 32'h0);
    chk(rd, 32'hFF);
    run(`MRSRE_OP_STACC, 1'h0, 7'h7F, 8'h00);
    chk(rd, 32'h7);
    chk(fmem[127], 32'hFF);
    fmem[5] <= 8'h81;
    bus(1'h1, 4'h8, 32'h0);
    run(`MRSRE_OP_ROTL, 1'h1, 7'h05, 8'h00);
    chk(rd, 32'h1);
    chk(fmem[5], 32'h02);
    run(`MRSRE_OP_ROTR, 1'h0, 7'h05, 8'h00);
    chk(rd, 32'h0);
    bus(1'h0, 4'h4, 32'h0);
    chk(rd, 32'h81);
    fmem[6] <= 8'h10;
    run(`MRSRE_OP_LDLIT, 1'h0, 7'h00, 8'h01);
    run(`MRSRE_OP_SUB, 1'h0, 7'h06, 8'h00);
    chk(rd, 32'h1);
    bus(1'h0, 4'h4, 32'h0);
    chk(rd, 32'h0F);
    run(`MRSRE_OP_LDLIT, 1'h0, 7'h00, 8'h10);
    run(`MRSRE_OP_SUB, 1'h1, 7'h06, 8'h00);
    chk(rd, 32'h7);
    chk(fmem[6], 32'h00);
    stack_top_entry <= 13'h1ABC;
    bus(1'h1, 4'h0, {28'h0, `MRSRE_OP_RET});
    run(`MRSRE_OP_NOP, 1'h0, 7'h00, 8'h00);
    chk(rd, 32'h7);
    bus(1'h0, 4'hC, 32'h0);
    chk(rd, 32'h1ABD);
    chk(npop, 1);
    stack_top_entry <= 13'h0123;
    run(`MRSRE_OP_RETI, 1'h0, 7'h00, 8'h00);
    chk(rd, 32'hF);
    bus(1'h0, 4'hC, 32'h0);
    chk(rd, 32'h0123);
    chk(npop, 2);
    stop_test;
  end
endmodule
